// ===== verilog/adc_ctrl_defines.svh
// Constants for the conversion control block.
// Assumes a single 100 MHz clock domain.
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

`define RES_W 8
`define CH_W 3
`define RES_MSB 3'h7
`define RES_LSB 3'h0
`define RES_ONE 8'h01
`define RESULT_RST 8'h00
`define DONE_PRIO 5'h14
`define SAMPLE_CYC 4'h4

`endif

// ===== verilog/adc_ctrl_pkg.sv
// Types for the conversion control block.
// Assumes adc_ctrl_defines.svh is on the include path.
`include "adc_ctrl_defines.svh"

package adc_ctrl_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_APPROX = 2'b10,
    ST_DONE = 2'b11
  } conv_state_t;

  // Software control image of the converter mode register
  typedef struct packed {
    logic sw_start;
    logic hw_start_en;
    logic [`CH_W-1:0] channel;
  } mode_t;

  // Analog front-end handshake: trial code out, comparator in
  typedef struct packed {
    logic [`CH_W-1:0] channel;
    logic [`RES_W-1:0] trial;
    logic sample;
  } afe_ctl_t;

endpackage

// ===== verilog/adc_conversion_control.sv
// Successive-approximation conversion controller, 8 bits, 8 channels.
// Assumes an analog comparator outside that answers within one cycle.
//
// Operation
// - Each finished 8-bit result goes into conversion_result_reg for reading.
// - One channel out of eight, chosen by software, is converted at once.
// - In hardware-start mode the trigger pin starts one conversion.
// - Writing the start setting into converter_mode_reg starts conversion.
// - A trigger-started conversion halts after its result until restarted.
// - Software-started conversion repeats back to back on the same channel.
// - Every finished conversion pulses the conversion-done interrupt request.
// - The done interrupt is maskable, default priority twenty, macro-capable.
`include "adc_ctrl_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module adc_conversion_control (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic mode_wr_i,
  input wire adc_ctrl_pkg::mode_t mode_i,
  input wire logic hw_trigger_input_i,
  input wire logic comp_high_i,
  output adc_ctrl_pkg::afe_ctl_t afe_o,
  output logic [`RES_W-1:0] conversion_result_reg_o,
  output logic busy_o,
  output logic conversion_done_irq_o,
  output logic [4:0] irq_priority_o,
  output logic irq_macro_ok_o
);
  import adc_ctrl_pkg::*;

  // ---------------------------------------------
  // Mode register
  // ---------------------------------------------
  mode_t converter_mode_reg;
  logic trig_meta_reg;
  logic trig_sync_reg;
  logic trig_prev_reg;
  logic trig_rise;
  conv_state_t state_reg;
  logic [`RES_W-1:0] sar_reg;
  logic [2:0] bit_reg;
  logic [3:0] wait_reg;
  logic [`RES_W-1:0] result_reg;
  logic done_reg;
  logic [`CH_W-1:0] conv_channel_reg;
  logic start_from_idle;
  logic start_again;

  // ---------------------------------------------
  // Bit helpers
  // ---------------------------------------------
  // One-hot weight of a result bit position
  function automatic logic [`RES_W-1:0] bit_mask(input logic [2:0] idx);
    bit_mask = `RES_ONE << idx;
  endfunction

  // Settles the bit under trial: kept when the input is at or above the
  // trial level, dropped otherwise. Shared by the sequencer and the result
  // path so both agree on the last bit.
  function automatic logic [`RES_W-1:0] settle_bit(
    input logic [`RES_W-1:0] code,
    input logic [2:0] idx,
    input logic keep
  );
    if (keep) begin
      settle_bit = code;
    end else begin
      settle_bit = code & ~bit_mask(idx);
    end
  endfunction

  // Offers the trial bit one position below idx, none below the LSB
  function automatic logic [`RES_W-1:0] next_trial(
    input logic [`RES_W-1:0] code,
    input logic [2:0] idx
  );
    if (idx == `RES_LSB) begin
      next_trial = code;
    end else begin
      next_trial = code | bit_mask(idx - 3'h1);
    end
  endfunction

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      converter_mode_reg <= '0;
    // Fields take effect from the cycle after the strobe
    end else if (mode_wr_i) begin
      converter_mode_reg <= mode_i;
    end
  end

  // ---------------------------------------------
  // Trigger pin synchroniser and rising edge
  // ---------------------------------------------
  // The pin is asynchronous: only the second flop feeds the edge detector,
  // so a metastable first stage never reaches the sequencer.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      trig_meta_reg <= 1'b0;
      trig_sync_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else begin
      trig_meta_reg <= hw_trigger_input_i;
      trig_sync_reg <= trig_meta_reg;
      trig_prev_reg <= trig_sync_reg;
    end
  end

  assign trig_rise = trig_sync_reg && !trig_prev_reg;

  // ---------------------------------------------
  // Start decode
  // ---------------------------------------------
  // A trigger edge counts only while idle; one arriving mid-conversion is
  // dropped, not queued.
  assign start_from_idle = converter_mode_reg.sw_start ||
    (converter_mode_reg.hw_start_en && trig_rise);
  assign start_again = converter_mode_reg.sw_start;

  // ---------------------------------------------
  // Channel hold
  // ---------------------------------------------
  // The selector follows the mode register only while idle, so a channel
  // write during a run cannot mix two inputs into one result. A new channel
  // takes effect once the run has stopped.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      conv_channel_reg <= '0;
    end else if (state_reg == ST_IDLE) begin
      conv_channel_reg <= converter_mode_reg.channel;
    end
  end

  // ---------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------
  // Clearing sw_start stops the repeat only after the current result lands,
  // so a stored result is never half-converted.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      sar_reg <= '0;
      bit_reg <= `RES_MSB;
      wait_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_from_idle) begin
            state_reg <= ST_SAMPLE;
            wait_reg <= '0;
          end
        end
        ST_SAMPLE: begin
          // Input held steady for the sample window before the first trial
          if (wait_reg == `SAMPLE_CYC - 4'h1) begin
            state_reg <= ST_APPROX;
            bit_reg <= `RES_MSB;
            sar_reg <= bit_mask(`RES_MSB);
          end else begin
            wait_reg <= wait_reg + 4'h1;
          end
        end
        ST_APPROX: begin
          // Settle the bit under trial, then offer the next lower one
          sar_reg <= next_trial(settle_bit(sar_reg, bit_reg, comp_high_i),
                                bit_reg);
          if (bit_reg == `RES_LSB) begin
            state_reg <= ST_DONE;
          end else begin
            bit_reg <= bit_reg - 3'h1;
          end
        end
        ST_DONE: begin
          if (start_again) begin
            state_reg <= ST_SAMPLE;
            wait_reg <= '0;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------
  // Result register and done request
  // ---------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      result_reg <= `RESULT_RST;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      // The last bit is settled here directly, at the same edge that loads it
      // into sar_reg, so the result and the request leave together.
      if (state_reg == ST_APPROX && bit_reg == `RES_LSB) begin
        result_reg <= settle_bit(sar_reg, `RES_LSB, comp_high_i);
        done_reg <= 1'b1;
      end
    end
  end

  // ---------------------------------------------
  // Outputs
  // ---------------------------------------------
  assign conversion_result_reg_o = result_reg;
  assign conversion_done_irq_o = done_reg;
  // Source attributes are fixed; masking is left to the interrupt
  // controller, which owns the mask flag for this source.
  assign irq_priority_o = `DONE_PRIO;
  assign irq_macro_ok_o = 1'b1;
  assign busy_o = (state_reg != ST_IDLE);
  assign afe_o.channel = conv_channel_reg;
  assign afe_o.trial = sar_reg;
  assign afe_o.sample = (state_reg == ST_SAMPLE);

endmodule
`default_nettype wire

// ===== verif/adc_ctrl_properties.sv
// Port checker for the conversion controller.
// Assumes a bind onto adc_conversion_control.
`timescale 1ns/1ns
`default_nettype none
module adc_ctrl_properties (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire adc_ctrl_pkg::afe_ctl_t afe_o,
  input wire logic [7:0] conversion_result_reg_o,
  input wire logic busy_o,
  input wire logic conversion_done_irq_o,
  input wire logic [4:0] irq_priority_o,
  input wire logic irq_macro_ok_o
);
  import adc_ctrl_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_irq_pulse: assert property (
    conversion_done_irq_o |=> !conversion_done_irq_o) else $error("irq width");
  a_conv_time: assert property (
    $rose(busy_o) |-> ##12 conversion_done_irq_o) else $error("irq late");
  a_trial_msb: assert property (
    $fell(afe_o.sample) |-> afe_o.trial == 8'h80) else $error("first trial");
  a_sample_len: assert property (
    $rose(afe_o.sample) |-> afe_o.sample[*4] ##1 !afe_o.sample)
    else $error("sample length");
  a_result_irq: assert property (
    $changed(conversion_result_reg_o) |-> conversion_done_irq_o)
    else $error("result w/o irq");
  a_chan_hold: assert property (
    busy_o && $past(busy_o) |-> $stable(afe_o.channel))
    else $error("channel moved");
  a_irq_prio: assert property (
    irq_priority_o == 5'h14) else $error("priority");
  a_irq_macro: assert property (
    irq_macro_ok_o) else $error("macro flag");
endmodule
`default_nettype wire

// ===== verif/adc_afe_model.sv
// Analog side: one level per channel and a comparator.
// Assumes the trial code is read in the cycle it is shown.
`timescale 1ns/1ns
`default_nettype none
module adc_afe_model (
  input wire adc_ctrl_pkg::afe_ctl_t afe_i,
  output logic comp_high_o
);
  import adc_ctrl_pkg::*;
  logic [7:0] level;
  // Distinct per channel so a wrong pick shows in the result
  assign level = {afe_i.channel, 5'h15};
  assign comp_high_o = level >= afe_i.trial;
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// Bench for adc_conversion_control with the analog model.
// Assumes the package and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import adc_ctrl_pkg::*;
  logic mclk_i = 1'h0, rst_n_i = 1'h0, wr_en = 1'h0, trig = 1'h0, comp;
  mode_t mode = '0;
  afe_ctl_t afe;
  logic [7:0] res;
  logic busy, irq, mok;
  logic [4:0] prio;
  int error_cnt = 0, cmp_count = 0;
  adc_conversion_control adc_conversion_control_i (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .mode_wr_i(wr_en), .mode_i(mode),
    .hw_trigger_input_i(trig), .comp_high_i(comp), .afe_o(afe),
    .conversion_result_reg_o(res), .busy_o(busy),
    .conversion_done_irq_o(irq), .irq_priority_o(prio),
    .irq_macro_ok_o(mok));
  adc_afe_model adc_afe_model_i (.afe_i(afe), .comp_high_o(comp));
  initial forever #5 mclk_i = ~mclk_i;
  task report_and_stop;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(string n, logic [7:0] got, logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask
  task wr(logic s, logic h, logic [2:0] c);
    @(posedge mclk_i);
    wr_en <= 1'h1;
    mode <= {s, h, c};
    @(posedge mclk_i);
    wr_en <= 1'h0;
  endtask
  task done(logic [2:0] c);
    int n;
    n = 0;
    do begin
      @(posedge mclk_i);
      #1 n++;
    end while (irq !== 1'h1 && n < 40);
    chk("irq", {7'h0, irq}, 8'h01);
    chk("result", res, {c, 5'h15});
  endtask
  task idle(string n, int k);
    repeat (k) @(posedge mclk_i);
    #1;
    chk(n, {7'h0, busy}, 8'h00);
  endtask
  task sw_run(logic [2:0] c);
    wr(1'h1, 1'h0, c);
    done(c);
    done(c);
    // Stop and pick another channel: the run in flight keeps its own
    wr(1'h0, 1'h0, ~c);
    done(c);
    idle("sw stop", 3);
  endtask
  task hw_run(logic [2:0] c);
    wr(1'h0, 1'h1, c);
    trig <= 1'h1;
    done(c);
    @(posedge mclk_i);
    trig <= 1'h0;
    idle("hw halt", 25);
  endtask
  task no_trig_run;
    wr(1'h0, 1'h0, 3'h0);
    trig <= 1'h1;
    idle("no trig", 10);
  endtask
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'h1;
    #1;
    chk("reset", res, 8'h00);
    chk("irq rst", {7'h0, irq}, 8'h00);
    chk("busy rst", {7'h0, busy}, 8'h00);
    chk("prio", {3'h0, prio}, 8'h14);
    chk("macro", {7'h0, mok}, 8'h01);
    for (int c = 0; c < 8; c++) begin
      sw_run(c[2:0]);
      hw_run(c[2:0]);
    end
    no_trig_run;
    report_and_stop;
  end
  initial begin
    #40000;
    error_cnt++;
    report_and_stop;
  end
endmodule
bind adc_conversion_control adc_ctrl_properties adc_ctrl_properties_i (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .afe_o(afe_o), .busy_o(busy_o),
  .conversion_result_reg_o(conversion_result_reg_o),
  .conversion_done_irq_o(conversion_done_irq_o),
  .irq_priority_o(irq_priority_o), .irq_macro_ok_o(irq_macro_ok_o));
`default_nettype wire
